// ### verilog/pcm_pkg.sv
// Shared constants for the print-mechanism controller and its host end.
package pcm_pkg;
	// =====================================================================
	// Clock and timing
	// =====================================================================
	localparam int CLK_NS = 20;
	localparam int FIRE_PULSE_US = 400;
	localparam int FIRE_CYCLES = (FIRE_PULSE_US * 1000) / CLK_NS;
	// Top carriage step rate in steps per second; a longest-rate figure.
	localparam int CAR_MAX_RATE_SPS = 500;
	localparam int CAR_MIN_GAP_CYCLES = (1000000000 / CLK_NS + CAR_MAX_RATE_SPS - 1) / CAR_MAX_RATE_SPS;
	localparam int LF_GAP_US = 5000;
	localparam int LF_GAP_CYCLES = (LF_GAP_US * 1000) / CLK_NS;
	localparam int LF_HOLD_US = 2000;
	localparam int LF_HOLD_CYCLES = (LF_HOLD_US * 1000) / CLK_NS;

	// =====================================================================
	// Mechanism figures
	// =====================================================================
	localparam int SW_COUNT = 7;
	localparam int DET_COUNT = 7;
	localparam int SENSE_W = SW_COUNT + DET_COUNT;
	localparam int SOL_COUNT = 7;
	localparam int FONT_HI_W = 7;
	localparam int FONT_LO_W = 4;
	localparam int FONT_AW = FONT_HI_W + FONT_LO_W;
	localparam int LF_STEPS_PER_LINE = 6;
	localparam logic [6:0] EOL_COL_NARROW = 7'd65;
	localparam logic [6:0] EOL_COL_WIDE = 7'd76;

	// Detector positions inside the detector group.
	localparam int DET_PAPER = 0;
	localparam int DET_TIME = 1;
	localparam int DET_SYNC = 2;
	localparam int DET_LBRAKE = 3;
	localparam int DET_FAN = 4;
	localparam int DET_SS = 5;
	localparam int DET_COVER = 6;

	// =====================================================================
	// Host register map (word index on the plain port)
	// =====================================================================
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_CMD = 3'h1;
	localparam logic [2:0] REG_FONT_HI = 3'h2;
	localparam logic [2:0] REG_FONT_WR = 3'h3;
	localparam logic [2:0] REG_SENSE = 3'h4;
	localparam logic [2:0] REG_STATUS = 3'h5;
	localparam logic [2:0] REG_MASK = 3'h6;

	localparam int CTRL_RIBBON = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_WIDE = 2;
	localparam int CTRL_PRINT = 3;
	localparam int CTRL_PSU_OFF = 4;
	localparam int CTRL_W = 5;
	localparam int CMD_STEP = 0;
	localparam int CMD_LF = 1;
	localparam int CMD_LINE = 2;
	localparam int FONT_WR_ADDR_LSB = 8;
	localparam int ST_CAR = 0;
	localparam int ST_FAN = 1;
	localparam int ST_LF = 2;
	localparam int ST_W = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
endpackage

// ### verilog/pcm_link_if.sv
// Link between the print-mechanism controller and its host processor end.
`timescale 1ns/1ps
interface pcm_link_if;
	logic [pcm_pkg::SENSE_W-1:0] sense;
	logic motor_irq;
	logic car_step;
	logic car_dir;
	logic lf_step;
	logic ribbon_on;
	logic print_en;
	logic line_wide;
	logic line_start;
	logic font_hi_ld;
	logic [pcm_pkg::FONT_HI_W-1:0] font_hi;
	logic font_wr;
	logic [pcm_pkg::FONT_AW-1:0] font_waddr;
	logic [pcm_pkg::SOL_COUNT-1:0] font_wdata;

	modport dev (
		output sense, motor_irq,
		input car_step, car_dir, lf_step, ribbon_on, print_en, line_wide, line_start,
		input font_hi_ld, font_hi, font_wr, font_waddr, font_wdata
	);
	modport host (
		input sense, motor_irq,
		output car_step, car_dir, lf_step, ribbon_on, print_en, line_wide, line_start,
		output font_hi_ld, font_hi, font_wr, font_waddr, font_wdata
	);
endinterface

// ### verilog/pcm_mech.sv
// Print-mechanism controller: sensing, motor phasing, step pacing, head firing.
`timescale 1ns/1ps
module pcm_mech #(
	parameter int FIRE_CYCLES = pcm_pkg::FIRE_CYCLES,
	parameter int CAR_MIN_GAP_CYCLES = pcm_pkg::CAR_MIN_GAP_CYCLES,
	parameter int LF_HOLD_CYCLES = pcm_pkg::LF_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link to the host
	pcm_link_if.dev link,
	// Switch and sensor pins
	input wire logic [pcm_pkg::SW_COUNT-1:0] sw_raw,
	input wire logic [pcm_pkg::DET_COUNT-1:0] det_raw,
	input wire logic fire_raw,
	// Mechanism drives
	output logic [3:0] car_phase,
	output logic [3:0] lf_phase,
	output logic lf_power,
	output logic ribbon_motor,
	output logic [pcm_pkg::SOL_COUNT-1:0] solenoid,
	output logic eol_alarm
);
	localparam int IN_W = pcm_pkg::SENSE_W + 1;
	localparam int FW = $clog2(FIRE_CYCLES + 1);
	localparam int GW = $clog2(CAR_MIN_GAP_CYCLES + 1);
	localparam int HW = $clog2(LF_HOLD_CYCLES + 1);

	if (FIRE_CYCLES < 1 || CAR_MIN_GAP_CYCLES < 1 || LF_HOLD_CYCLES < 1) begin : g_bad_param
		$error("pcm_mech: timing counts must be at least one cycle");
	end

	// =====================================================================
	// Input synchronisers
	// =====================================================================
	logic [IN_W-1:0] in_meta_reg;
	logic [IN_W-1:0] in_sync_reg;
	logic [IN_W-1:0] in_prev_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_meta_reg <= '0;
			in_sync_reg <= '0;
			in_prev_reg <= '0;
		end else begin
			in_meta_reg <= {fire_raw, det_raw, sw_raw};
			in_sync_reg <= in_meta_reg;
			in_prev_reg <= in_sync_reg;
		end
	end

	logic time_rise;
	logic fire_rise;
	assign time_rise = in_sync_reg[pcm_pkg::SW_COUNT + pcm_pkg::DET_TIME]
		& ~in_prev_reg[pcm_pkg::SW_COUNT + pcm_pkg::DET_TIME];
	assign fire_rise = in_sync_reg[IN_W-1] & ~in_prev_reg[IN_W-1];

	// =====================================================================
	// Sense word for the host
	// =====================================================================
	// The fire sensor is the top synchronised bit and is left out on purpose.
	logic [pcm_pkg::SENSE_W-1:0] sense_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sense_reg <= '0;
		end else begin
			sense_reg <= in_sync_reg[pcm_pkg::SENSE_W-1:0];
		end
	end
	assign link.sense = sense_reg;

	// =====================================================================
	// Carriage interrupt
	// =====================================================================
	// A disc pulse in the same cycle as the host step re-arms the flag.
	logic irq_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else if (time_rise) begin
			irq_reg <= 1'b1;
		end else if (link.car_step) begin
			irq_reg <= 1'b0;
		end
	end
	assign link.motor_irq = irq_reg;

	// =====================================================================
	// Start-stop pacing
	// =====================================================================
	// A step that comes too early is held and issued once the gap has run out; only one step is held,
	// so a second early step merges into it, and the host cannot push the motor past its rate.
	logic [GW-1:0] gap_reg;
	logic step_wait_reg;
	logic car_go;
	assign car_go = (link.car_step | step_wait_reg) && (gap_reg == GW'(CAR_MIN_GAP_CYCLES));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_reg <= GW'(CAR_MIN_GAP_CYCLES);
			step_wait_reg <= 1'b0;
		end else begin
			if (car_go) begin
				gap_reg <= '0;
			end else if (gap_reg != GW'(CAR_MIN_GAP_CYCLES)) begin
				gap_reg <= gap_reg + GW'(1);
			end
			step_wait_reg <= (link.car_step | step_wait_reg) & ~car_go;
		end
	end

	// =====================================================================
	// Phase generators
	// =====================================================================
	logic [1:0] gen_step;
	logic [1:0] gen_dir;
	logic [1:0] gen_idx_reg [2];
	logic [3:0] gen_phase_reg [2];
	assign gen_step = {link.lf_step, car_go};
	assign gen_dir = {1'b0, link.car_dir};
	for (genvar g = 0; g < 2; g++) begin : g_phase
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				gen_idx_reg[g] <= 2'h0;
				gen_phase_reg[g] <= 4'h1;
			end else if (gen_step[g]) begin
				gen_idx_reg[g] <= gen_dir[g] ? gen_idx_reg[g] - 2'h1 : gen_idx_reg[g] + 2'h1;
				gen_phase_reg[g] <= 4'h1 << (gen_dir[g] ? gen_idx_reg[g] - 2'h1 : gen_idx_reg[g] + 2'h1);
			end
		end
	end
	assign car_phase = gen_phase_reg[0];
	assign lf_phase = gen_phase_reg[1];

	// =====================================================================
	// Line-feed power and ribbon
	// =====================================================================
	logic [HW-1:0] hold_reg;
	logic lf_power_reg;
	logic ribbon_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_reg <= '0;
			lf_power_reg <= 1'b0;
			ribbon_reg <= 1'b0;
		end else begin
			if (link.lf_step) begin
				hold_reg <= HW'(LF_HOLD_CYCLES);
			end else if (hold_reg != '0) begin
				hold_reg <= hold_reg - HW'(1);
			end
			lf_power_reg <= link.lf_step | (hold_reg > HW'(1));
			ribbon_reg <= link.ribbon_on;
		end
	end
	assign lf_power = lf_power_reg;
	assign ribbon_motor = ribbon_reg;

	// =====================================================================
	// Font address and memory
	// =====================================================================
	logic [pcm_pkg::FONT_HI_W-1:0] font_hi_reg;
	logic [pcm_pkg::FONT_LO_W-1:0] col_reg;
	logic [pcm_pkg::SOL_COUNT-1:0] font_mem [2**pcm_pkg::FONT_AW];
	logic fire_go;
	logic [FW-1:0] fire_reg;
	assign fire_go = fire_rise & link.print_en & (fire_reg == '0);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			font_hi_reg <= '0;
			col_reg <= '0;
		end else if (link.font_hi_ld) begin
			font_hi_reg <= link.font_hi;
			col_reg <= link.car_dir ? '1 : '0;
		end else if (fire_go) begin
			col_reg <= link.car_dir ? col_reg - 4'h1 : col_reg + 4'h1;
		end
	end

	// The pattern store has no reset; the host loads it before printing.
	always_ff @(posedge clk) begin
		if (link.font_wr) begin
			font_mem[link.font_waddr] <= link.font_wdata;
		end
	end

	// =====================================================================
	// Head firing
	// =====================================================================
	// A fire edge during a running pulse is dropped, keeping one pulse per event.
	logic [pcm_pkg::SOL_COUNT-1:0] sol_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fire_reg <= '0;
			sol_reg <= '0;
		end else if (fire_go) begin
			fire_reg <= FW'(FIRE_CYCLES);
			sol_reg <= font_mem[{font_hi_reg, col_reg}];
		end else if (fire_reg != '0) begin
			fire_reg <= fire_reg - FW'(1);
			if (fire_reg == FW'(1)) begin
				sol_reg <= '0;
			end
		end
	end
	assign solenoid = sol_reg;

	// =====================================================================
	// End-of-line alarm
	// =====================================================================
	logic [6:0] char_cnt_reg;
	logic eol_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			char_cnt_reg <= '0;
			eol_reg <= 1'b0;
		end else begin
			if (link.line_start) begin
				char_cnt_reg <= '0;
			end else if (link.font_hi_ld && char_cnt_reg != 7'h7F) begin
				char_cnt_reg <= char_cnt_reg + 7'h01;
			end
			eol_reg <= ~link.line_start
				& (char_cnt_reg >= (link.line_wide ? pcm_pkg::EOL_COL_WIDE : pcm_pkg::EOL_COL_NARROW));
		end
	end
	assign eol_alarm = eol_reg;
endmodule // pcm_mech

// ### verilog/pcm_host.sv
// Host end: register port for software, drives the link to the controller.
`timescale 1ns/1ps
module pcm_host #(
	parameter int LF_GAP_CYCLES = pcm_pkg::LF_GAP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Software register port
	input wire logic [2:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	// Power supply command
	output logic psu_off,
	// Link to the controller
	pcm_link_if.host link
);
	localparam int LW = $clog2(LF_GAP_CYCLES + 1);

	if (LF_GAP_CYCLES < 1) begin : g_bad_param
		$error("pcm_host: line-feed gap must be at least one cycle");
	end

	typedef enum logic [1:0] {PCM_LF_IDLE, PCM_LF_STEP, PCM_LF_GAP} pcm_lf_state_t;

	logic wr_ctrl;
	logic wr_cmd;
	assign wr_ctrl = wr && addr == pcm_pkg::REG_CTRL;
	assign wr_cmd = wr && addr == pcm_pkg::REG_CMD;

	// =====================================================================
	// Control register and command pulses
	// =====================================================================
	// A step order is refused unless an interrupt is pending and none was just
	// answered, so steps and interrupts stay one to one.
	logic [pcm_pkg::CTRL_W-1:0] ctrl_reg;
	logic step_reg;
	logic line_reg;
	logic hi_ld_reg;
	logic [pcm_pkg::FONT_HI_W-1:0] hi_reg;
	logic fwr_reg;
	logic [pcm_pkg::FONT_AW-1:0] faddr_reg;
	logic [pcm_pkg::SOL_COUNT-1:0] fdata_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= pcm_pkg::CTRL_RESET;
			step_reg <= 1'b0;
			line_reg <= 1'b0;
			hi_ld_reg <= 1'b0;
			hi_reg <= '0;
			fwr_reg <= 1'b0;
			faddr_reg <= '0;
			fdata_reg <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wdata[pcm_pkg::CTRL_W-1:0];
			end
			step_reg <= wr_cmd & wdata[pcm_pkg::CMD_STEP] & link.motor_irq & ~step_reg;
			line_reg <= wr_cmd & wdata[pcm_pkg::CMD_LINE];
			hi_ld_reg <= wr && addr == pcm_pkg::REG_FONT_HI;
			if (wr && addr == pcm_pkg::REG_FONT_HI) begin
				hi_reg <= wdata[pcm_pkg::FONT_HI_W-1:0];
			end
			fwr_reg <= wr && addr == pcm_pkg::REG_FONT_WR;
			if (wr && addr == pcm_pkg::REG_FONT_WR) begin
				fdata_reg <= wdata[pcm_pkg::SOL_COUNT-1:0];
				faddr_reg <= wdata[pcm_pkg::FONT_WR_ADDR_LSB +: pcm_pkg::FONT_AW];
			end
		end
	end
	assign link.car_step = step_reg;
	assign link.car_dir = ctrl_reg[pcm_pkg::CTRL_DIR];
	assign link.ribbon_on = ctrl_reg[pcm_pkg::CTRL_RIBBON];
	assign link.print_en = ctrl_reg[pcm_pkg::CTRL_PRINT];
	assign link.line_wide = ctrl_reg[pcm_pkg::CTRL_WIDE];
	assign link.line_start = line_reg;
	assign link.font_hi_ld = hi_ld_reg;
	assign link.font_hi = hi_reg;
	assign link.font_wr = fwr_reg;
	assign link.font_waddr = faddr_reg;
	assign link.font_wdata = fdata_reg;

	// =====================================================================
	// Line-feed sequencer
	// =====================================================================
	pcm_lf_state_t lf_state_reg;
	logic [2:0] lf_cnt_reg;
	logic [LW-1:0] lf_gap_reg;
	logic lf_step_reg;
	logic lf_done;
	assign lf_done = lf_state_reg == PCM_LF_GAP && lf_gap_reg == '0
		&& lf_cnt_reg == 3'(pcm_pkg::LF_STEPS_PER_LINE);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lf_state_reg <= PCM_LF_IDLE;
			lf_cnt_reg <= '0;
			lf_gap_reg <= '0;
			lf_step_reg <= 1'b0;
		end else begin
			lf_step_reg <= 1'b0;
			unique case (lf_state_reg)
				PCM_LF_IDLE: begin
					if (wr_cmd && wdata[pcm_pkg::CMD_LF]) begin
						lf_cnt_reg <= '0;
						lf_state_reg <= PCM_LF_STEP;
					end
				end
				PCM_LF_STEP: begin
					lf_step_reg <= 1'b1;
					lf_cnt_reg <= lf_cnt_reg + 3'h1;
					lf_gap_reg <= LW'(LF_GAP_CYCLES);
					lf_state_reg <= PCM_LF_GAP;
				end
				PCM_LF_GAP: begin
					if (lf_gap_reg != '0) begin
						lf_gap_reg <= lf_gap_reg - LW'(1);
					end else if (lf_cnt_reg == 3'(pcm_pkg::LF_STEPS_PER_LINE)) begin
						lf_state_reg <= PCM_LF_IDLE;
					end else begin
						lf_state_reg <= PCM_LF_STEP;
					end
				end
			endcase
		end
	end
	assign link.lf_step = lf_step_reg;

	// =====================================================================
	// Status, mask, interrupt and read data
	// =====================================================================
	logic irq_prev_reg;
	logic fan_prev_reg;
	logic [pcm_pkg::ST_W-1:0] status_reg;
	logic [pcm_pkg::ST_W-1:0] mask_reg;
	logic [pcm_pkg::ST_W-1:0] ev;
	logic [pcm_pkg::ST_W-1:0] clr;
	logic fan_bit;
	logic irq_reg;
	logic psu_reg;
	logic [31:0] rdata_reg;
	assign fan_bit = link.sense[pcm_pkg::SW_COUNT + pcm_pkg::DET_FAN];
	assign ev = {lf_done, fan_bit & ~fan_prev_reg, link.motor_irq & ~irq_prev_reg};
	assign clr = (wr && addr == pcm_pkg::REG_STATUS) ? wdata[pcm_pkg::ST_W-1:0] : '0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_prev_reg <= 1'b0;
			fan_prev_reg <= 1'b0;
			status_reg <= '0;
			mask_reg <= pcm_pkg::MASK_RESET;
			irq_reg <= 1'b0;
			psu_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			irq_prev_reg <= link.motor_irq;
			fan_prev_reg <= fan_bit;
			status_reg <= (status_reg & ~clr) | ev;
			if (wr && addr == pcm_pkg::REG_MASK) begin
				mask_reg <= wdata[pcm_pkg::ST_W-1:0];
			end
			irq_reg <= |(((status_reg & ~clr) | ev) & mask_reg);
			// Shutdown is software's order; it prints the fan message first.
			psu_reg <= ctrl_reg[pcm_pkg::CTRL_PSU_OFF];
			rdata_reg <= '0;
			if (rd) begin
				unique case (addr)
					pcm_pkg::REG_CTRL: rdata_reg <= 32'(ctrl_reg);
					pcm_pkg::REG_CMD: rdata_reg <= {30'h0000_0000, lf_state_reg != PCM_LF_IDLE, link.motor_irq};
					pcm_pkg::REG_FONT_HI: rdata_reg <= 32'(hi_reg);
					pcm_pkg::REG_SENSE: rdata_reg <= 32'(link.sense);
					pcm_pkg::REG_STATUS: rdata_reg <= 32'(status_reg);
					pcm_pkg::REG_MASK: rdata_reg <= 32'(mask_reg);
					default: rdata_reg <= '0;
				endcase
			end
		end
	end
	assign rdata = rdata_reg;
	assign irq = irq_reg;
	assign psu_off = psu_reg;
endmodule // pcm_host

// ### verif/pcm_link_checker.sv
// Concurrent checks on the link between the controller and its host end.
`timescale 1ns/1ps
module pcm_link_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link signals
	input wire logic [pcm_pkg::SENSE_W-1:0] sense,
	input wire logic motor_irq,
	input wire logic car_step,
	input wire logic lf_step
);
	logic [3:0] lf_cnt_reg;
	logic [4:0] lf_idle_reg;

	// =====================================================================
	// Line-feed burst count
	// =====================================================================
	// Sixteen quiet cycles end a burst; steps inside a burst are seven apart.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lf_cnt_reg <= 4'h0;
			lf_idle_reg <= 5'h00;
		end else if (lf_step) begin
			lf_cnt_reg <= lf_cnt_reg + 4'h1;
			lf_idle_reg <= 5'h00;
		end else if (lf_idle_reg == 5'h10) begin
			lf_cnt_reg <= 4'h0;
		end else begin
			lf_idle_reg <= lf_idle_reg + 5'h01;
		end
	end

	// =====================================================================
	// Properties
	// =====================================================================
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_STEP_NEEDS_IRQ: assert property (car_step |-> motor_irq)
		else $error("carriage step sent without a pending interrupt");
	AST_STEP_SPACED: assert property (car_step |=> !car_step)
		else $error("two carriage steps in adjacent cycles");
	AST_IRQ_CLEARED: assert property (car_step |=> !motor_irq)
		else $error("interrupt not cleared by its step");
	AST_IRQ_HELD: assert property (motor_irq && !car_step |=> motor_irq)
		else $error("pending interrupt dropped without a step");
	AST_IRQ_FALL_CAUSE: assert property ($fell(motor_irq) |-> $past(car_step))
		else $error("interrupt fell with no step before it");
	AST_IRQ_FROM_DISC: assert property ($rose(motor_irq) |-> ##[0:4] sense[pcm_pkg::SW_COUNT+pcm_pkg::DET_TIME])
		else $error("interrupt raised with no timing disc pulse");
	AST_LF_GAP: assert property (lf_step |=> !lf_step [*6])
		else $error("line-feed steps too close");
	AST_LF_SIX: assert property (lf_step |-> lf_cnt_reg < 4'h6)
		else $error("more than six line-feed steps in one line");

	cover property (car_step);
	cover property (lf_step ##7 lf_step);
	cover property ($rose(motor_irq));
endmodule // pcm_link_checker

// ### verif/printer_carriage_motor_control_tb.sv
// Self-checking bench for the controller and host end joined by their link.
`timescale 1ns/1ps
module printer_carriage_motor_control_tb;
	localparam int FIRE = 20;
	localparam int CGAP = 40;
	localparam int HOLD = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] sw_raw = 7'h00;
	logic [6:0] det_raw = 7'h00;
	logic fire_raw = 1'b0;
	logic [31:0] rdata, v;
	logic irq, psu_off, lf_power, ribbon_motor, eol_alarm;
	logic [3:0] car_phase, lf_phase;
	logic [3:0] car_prev = 4'h1;
	logic [3:0] lf_prev = 4'h1;
	logic [6:0] solenoid;
	logic [6:0] pat [2];
	int car_cyc, car_moves, lf_moves, error_cnt, samples_checked, k, n, m, lim;

	pcm_link_if link ();
	always #10 clk = ~clk;
	pcm_mech #(.FIRE_CYCLES(FIRE), .CAR_MIN_GAP_CYCLES(CGAP), .LF_HOLD_CYCLES(HOLD)) i_pcm_mech (.clk(clk),
		.rst(rst), .link(link), .sw_raw(sw_raw), .det_raw(det_raw), .fire_raw(fire_raw), .car_phase(car_phase),
		.lf_phase(lf_phase), .lf_power(lf_power), .ribbon_motor(ribbon_motor), .solenoid(solenoid), .eol_alarm(eol_alarm));
	pcm_host #(.LF_GAP_CYCLES(5)) i_pcm_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .psu_off(psu_off), .link(link));
	pcm_link_checker i_pcm_link_checker (.clk(clk), .rst(rst), .sense(link.sense), .motor_irq(link.motor_irq),
		.car_step(link.car_step), .lf_step(link.lf_step));

	// =====================================================================
	// Helpers
	// =====================================================================
	function automatic logic [3:0] rotl(input logic [3:0] p, input int s);
		return 4'((p << (s % 4)) | (p >> (4 - s % 4)));
	endfunction

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t register read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t output %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic timed_out(input logic ok);
		if (!ok) begin
			error_cnt++;
			$display("BAD %0t wait ran out", $time);
			complete_run();
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Timing disc pulse, then one step once the interrupt is seen.
	task automatic step_car();
		m = car_moves;
		@(posedge clk);
		det_raw[pcm_pkg::DET_TIME] <= 1'b1;
		repeat (8) @(posedge clk);
		det_raw[pcm_pkg::DET_TIME] <= 1'b0;
		for (n = 0; n < 20 && link.motor_irq !== 1'b1; n++) @(negedge clk);
		timed_out(link.motor_irq === 1'b1);
		wr_reg(pcm_pkg::REG_CMD, 32'h0000_0001);
		// The move counter changes on the falling edge, so it is polled on the rising one.
		for (n = 0; n < 100 && car_moves == m; n++) @(posedge clk);
		timed_out(car_moves != m);
		@(negedge clk);
	endtask

	always @(negedge clk) begin
		car_cyc++;
		if (!rst && car_phase !== car_prev) begin
			if (car_moves > 0) chk_pin(car_cyc >= CGAP, 1);
			car_moves++;
			car_cyc = 0;
		end
		if (!rst && lf_phase !== lf_prev) lf_moves++;
		car_prev = car_phase;
		lf_prev = lf_phase;
	end

	// =====================================================================
	// Main sequence
	// =====================================================================
	initial begin
		void'($urandom(32'h7c58));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk_pin({car_phase, lf_phase, lf_power, ribbon_motor, solenoid, eol_alarm, psu_off, irq}, 32'h0001_1000);
		rd_reg(pcm_pkg::REG_CTRL);
		chk_reg(v, 32'h0000_0000);
		rd_reg(pcm_pkg::REG_MASK);
		chk_reg(v, 32'h0000_0000);
		rd_reg(3'h7);
		chk_reg(v, 32'h0000_0000);
		for (k = 0; k < 4; k++) begin
			sw_raw <= (k == 0) ? 7'h7f : 7'($urandom);
			det_raw <= (k == 0) ? 7'h6d : 7'($urandom) & 7'h6d;
			// The fire sensor toggles with printing off; it must never reach the sense word.
			fire_raw <= k[0];
			repeat (5) @(posedge clk);
			rd_reg(pcm_pkg::REG_SENSE);
			chk_reg(v, {18'h0_0000, det_raw, sw_raw});
		end
		det_raw <= 7'h00;
		fire_raw <= 1'b0;
		wr_reg(pcm_pkg::REG_MASK, 32'h0000_0001);
		for (k = 0; k < 3; k++) step_car();
		chk_pin(irq, 1);
		wr_reg(pcm_pkg::REG_STATUS, 32'h0000_0001);
		repeat (2) @(negedge clk);
		chk_pin(irq, 0);
		wr_reg(pcm_pkg::REG_CMD, 32'h0000_0001);
		repeat (CGAP + 5) @(negedge clk);
		chk_pin(car_moves, 3);
		wr_reg(pcm_pkg::REG_CTRL, 32'h0000_0002);
		wr_reg(pcm_pkg::REG_MASK, 32'h0000_0000);
		step_car();
		chk_pin(irq, 0);
		rd_reg(pcm_pkg::REG_STATUS);
		chk_reg(v & 32'h1, 32'h1);
		chk_pin(car_phase, rotl(4'h1, 2));
		wr_reg(pcm_pkg::REG_MASK, 32'h0000_0004);
		wr_reg(pcm_pkg::REG_CMD, 32'h0000_0002);
		for (n = 0; n < 50 && lf_moves < 1; n++) @(posedge clk);
		timed_out(lf_moves >= 1);
		repeat (2) @(negedge clk);
		chk_pin(lf_power, 1);
		for (n = 0; n < 200 && lf_moves < 6; n++) @(posedge clk);
		timed_out(lf_moves == 6);
		// Done is flagged once the gap after the sixth step has run down.
		repeat (5) @(negedge clk);
		chk_pin(irq, 1);
		rd_reg(pcm_pkg::REG_STATUS);
		chk_reg(v & 32'h4, 32'h4);
		repeat (HOLD + 10) @(negedge clk);
		chk_pin({lf_power, lf_phase}, {1'b0, rotl(4'h1, 6)});
		chk_pin(lf_moves, 6);
		wr_reg(pcm_pkg::REG_STATUS, 32'h0000_0004);
		repeat (2) @(negedge clk);
		chk_pin(irq, 0);
		wr_reg(pcm_pkg::REG_MASK, 32'h0000_0002);
		det_raw[pcm_pkg::DET_FAN] <= 1'b1;
		repeat (6) @(negedge clk);
		chk_pin(irq, 1);
		wr_reg(pcm_pkg::REG_CTRL, 32'h0000_0011);
		repeat (3) @(negedge clk);
		chk_pin({psu_off, ribbon_motor}, 2'b11);
		for (k = 0; k < 2; k++) begin
			pat[k] = 7'($urandom) | 7'h01;
			wr_reg(pcm_pkg::REG_FONT_WR, {13'h0000, 7'h03, 4'(k), 1'b0, pat[k]});
		end
		wr_reg(pcm_pkg::REG_CTRL, 32'h0000_0009);
		wr_reg(pcm_pkg::REG_FONT_HI, 32'h0000_0003);
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			fire_raw <= 1'b1;
			repeat (3) @(posedge clk);
			fire_raw <= 1'b0;
			for (n = 0; n < 20 && solenoid === 7'h00; n++) @(negedge clk);
			chk_pin(solenoid, pat[k]);
			for (n = 0; n < 100 && solenoid !== 7'h00; n++) @(negedge clk);
			chk_pin(n, FIRE);
		end
		for (k = 0; k < 2; k++) begin
			wr_reg(pcm_pkg::REG_CMD, 32'h0000_0004);
			wr_reg(pcm_pkg::REG_CTRL, k << 2);
			lim = k ? 76 : 65;
			for (m = 1; m <= lim; m++) begin
				wr_reg(pcm_pkg::REG_FONT_HI, 32'($urandom) & 32'h7f);
				// Load pulse, count and alarm each take one register stage.
				repeat (3) @(negedge clk);
				if (m >= lim - 1) chk_pin(eol_alarm, m == lim);
			end
		end
		wr_reg(pcm_pkg::REG_CMD, 32'h0000_0004);
		repeat (2) @(negedge clk);
		chk_pin(eol_alarm, 0);
		complete_run();
	end
endmodule // printer_carriage_motor_control_tb
